// file: rtl/feature_config_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "feature_config_map.svh"

module feature_config_decoder
  import feature_config_pkg::*;
#(
  parameter int          ENTRIES   = 64,
  parameter logic [63:0] NS_BLOCKS = 64'h0000_0000_0010_0000,
  parameter logic [127:0] RANGE_ID =
    128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978
)(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [12:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  output var  arb_s        arb_o,
  output var  pwr_s        pwr_o,
  output var  logic        power_state_load_o
);
  // RANGE_ID value is arbitrary

  localparam int WORDS = ENTRIES * 16;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_e      state_reg;
  copy_mode_e  mode_reg;
  logic [9:0]  copy_w_reg;
  logic [5:0]  ci_reg;
  logic [5:0]  cj_reg;
  logic [5:0]  num_reg;
  logic [5:0]  lba_num_reg;
  logic [31:0] arg10_reg;
  logic [31:0] arg11_reg;
  logic        set_reg;
  logic        start_reg;
  logic        crst_reg;
  logic        done_reg;
  logic [7:0]  status_reg;
  logic [31:0] result_reg;
  logic [31:0] caps_reg;
  arb_s        arb_reg;
  pwr_s        pwr_reg;
  logic        load_reg;
  logic [31:0] hmb_reg;
  logic [31:0] mark_reg;
  logic [63:0] hostid_reg;
  logic [31:0] rmask_reg;
  logic [31:0] rpers_reg;
  logic [7:0]  saved_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] xfer_mem  [WORDS];
  logic [31:0] store_mem [WORDS];
  logic [63:0] range_start_sh [ENTRIES];
  logic [63:0] range_count_sh [ENTRIES];

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] feat_idx(input logic [7:0] sel);
    unique case (sel)
      `SEL_ARB:    feat_idx = 3'd0;
      `SEL_PWR:    feat_idx = 3'd1;
      `SEL_LBA:    feat_idx = 3'd2;
      `SEL_MARK:   feat_idx = 3'd3;
      `SEL_HOSTID: feat_idx = 3'd4;
      `SEL_RMASK:  feat_idx = 3'd5;
      `SEL_RPERS:  feat_idx = 3'd6;
      default:     feat_idx = 3'd7;
    endcase
  endfunction : feat_idx

  function automatic logic [31:0] dflt_word(input logic [9:0] w);
    logic [63:0] last_blk;
    last_blk = NS_BLOCKS - 64'h1;
    unique case (w)
      10'd0:   dflt_word = {16'h0, `LBA_ATTR_RST, `LBA_TYPE_RST};
      10'd6:   dflt_word = last_blk[31:0];
      10'd7:   dflt_word = last_blk[63:32];
      10'd8:   dflt_word = RANGE_ID[31:0];
      10'd9:   dflt_word = RANGE_ID[63:32];
      10'd10:  dflt_word = RANGE_ID[95:64];
      10'd11:  dflt_word = RANGE_ID[127:96];
      default: dflt_word = 32'h0;
    endcase
  endfunction : dflt_word

  logic [7:0]  sel;
  logic        save_sup;
  logic [4:0]  psc;
  logic [7:0]  sc_next;
  logic        go;
  logic        acc;
  logic        feat_ok;
  logic [7:0]  persist;
  logic [31:0] get_val;

  assign sel      = arg10_reg[7:0];
  assign save_sup = caps_reg[`CAPS_SAVE_BIT];
  assign psc      = caps_reg[`CAPS_PSC_LSB +: 5];
  assign go       = start_reg && (state_reg == ST_IDLE);
  assign acc      = go && (sc_next == `SC_OK);
  // Persistence column only counts without save support
  assign persist  = save_sup ? saved_reg : `PERSIST_COLS;

  always_comb begin
    unique case (sel)
      `SEL_ARB, `SEL_PWR, `SEL_LBA, `SEL_HMB, `SEL_MARK: feat_ok = 1'b1;
      `SEL_HOSTID: feat_ok = caps_reg[`CAPS_RESV_BIT];
      `SEL_RMASK, `SEL_RPERS: feat_ok = caps_reg[`CAPS_RCAP_BIT];
      default: feat_ok = 1'b0;
    endcase
    sc_next = `SC_OK;
    if (!feat_ok) begin
      sc_next = `SC_INVALID;
    end else if (set_reg && arg10_reg[`SAVE_BIT] &&
                 (!save_sup || sel == `SEL_HMB)) begin
      sc_next = `SC_NOSAVE;
    end else if (set_reg && sel == `SEL_PWR && arg11_reg[4:0] > psc) begin
      sc_next = `SC_INVALID;
    end
  end

  always_comb begin
    unique case (sel)
      `SEL_ARB:   get_val = {arb_reg[26:3], 5'h0, arb_reg[2:0]};
      `SEL_PWR:   get_val = {24'h0, pwr_reg};
      `SEL_LBA:   get_val = {26'h0, lba_num_reg};
      `SEL_HMB:   get_val = hmb_reg;
      `SEL_MARK:  get_val = mark_reg;
      `SEL_RMASK: get_val = rmask_reg;
      `SEL_RPERS: get_val = rpers_reg;
      default:    get_val = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  logic        overlap;
  logic [64:0] a_end;
  logic [64:0] b_end;

  assign a_end   = {1'b0, range_start_sh[ci_reg]} +
                   {1'b0, range_count_sh[ci_reg]};
  assign b_end   = {1'b0, range_start_sh[cj_reg]} +
                   {1'b0, range_count_sh[cj_reg]};
  assign overlap = ({1'b0, range_start_sh[ci_reg]} <= b_end) &&
                   ({1'b0, range_start_sh[cj_reg]} <= a_end);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_COPY;
      mode_reg    <= CP_INIT;
      copy_w_reg  <= 10'h0;
      ci_reg      <= 6'h0;
      cj_reg      <= 6'h0;
      num_reg     <= 6'h0;
      lba_num_reg <= 6'h0;
      status_reg  <= `SC_OK;
      result_reg  <= 32'h0;
      done_reg    <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go) begin
            status_reg <= sc_next;
            result_reg <= (acc && !set_reg) ? get_val : 32'h0;
            done_reg   <= 1'b1;
            copy_w_reg <= 10'h0;
            if (acc && sel == `SEL_LBA) begin
              done_reg <= 1'b0;
              num_reg  <= arg11_reg[5:0];
              ci_reg   <= 6'h0;
              cj_reg   <= 6'h1;
              mode_reg <= set_reg ? CP_SET : CP_GET;
              state_reg <= (set_reg && arg11_reg[5:0] != 6'h0) ?
                           ST_CHECK : ST_COPY;
            end
          end else if (crst_reg && !persist[2]) begin
            lba_num_reg <= 6'h0;
            mode_reg    <= CP_INIT;
            copy_w_reg  <= 10'h0;
            state_reg   <= ST_COPY;
          end
        end
        ST_CHECK: begin
          if (overlap) begin
            status_reg <= `SC_OVERLAP;
            done_reg   <= 1'b1;
            state_reg  <= ST_IDLE;
          end else if (cj_reg != num_reg) begin
            cj_reg <= cj_reg + 6'h1;
          end else if (ci_reg + 6'h1 < num_reg) begin
            ci_reg <= ci_reg + 6'h1;
            cj_reg <= ci_reg + 6'h2;
          end else begin
            state_reg <= ST_COPY;
          end
        end
        ST_COPY: begin
          copy_w_reg <= copy_w_reg + 10'h1;
          if (copy_w_reg == 10'(WORDS - 1)) begin
            state_reg <= ST_IDLE;
            done_reg  <= (mode_reg != CP_INIT);
            if (mode_reg == CP_SET) begin
              lba_num_reg <= num_reg;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (start_reg && state_reg == ST_IDLE && !go) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Feature values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arb_reg    <= `ARB_RST;
      pwr_reg    <= `PWR_RST;
      load_reg   <= 1'b0;
      hmb_reg    <= 32'h0;
      mark_reg   <= 32'h0;
      hostid_reg <= 64'h0;
      rmask_reg  <= 32'h0;
      rpers_reg  <= 32'h0;
      saved_reg  <= 8'h0;
    end else begin
      load_reg <= acc && set_reg && sel == `SEL_PWR;
      if (acc && set_reg) begin
        if (arg10_reg[`SAVE_BIT]) begin
          saved_reg[feat_idx(sel)] <= 1'b1;
        end
        unique case (sel)
          `SEL_ARB: begin
            arb_reg <= {arg11_reg[31:8], arg11_reg[2:0]};
          end
          `SEL_PWR: begin
            pwr_reg <= arg11_reg[7:0];
            hmb_reg <= 32'h0;
          end
          `SEL_HMB:    hmb_reg    <= arg11_reg;
          `SEL_MARK:   mark_reg   <= arg11_reg;
          `SEL_HOSTID: hostid_reg <= {xfer_mem[1], xfer_mem[0]};
          `SEL_RMASK:  rmask_reg  <= arg11_reg;
          `SEL_RPERS:  rpers_reg  <= arg11_reg;
          default: ;
        endcase
      end else if (crst_reg && state_reg == ST_IDLE && !start_reg) begin
        hmb_reg <= 32'h0;
        if (!persist[0]) arb_reg    <= `ARB_RST;
        if (!persist[1]) pwr_reg    <= `PWR_RST;
        if (!persist[3]) mark_reg   <= 32'h0;
        if (!persist[4]) hostid_reg <= 64'h0;
        if (!persist[5]) rmask_reg  <= 32'h0;
        if (!persist[6]) rpers_reg  <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Range store and transfer buffer
  // ----------------------------------------------------------------
  logic        xw_en;
  logic [9:0]  xw_addr;
  logic [31:0] xw_data;
  logic        wr_en;
  logic        hid_get;

  assign wr_en   = psel_i && penable_i && pready_reg && pwrite_i &&
                   !pslverr_reg;
  assign hid_get = acc && !set_reg && sel == `SEL_HOSTID;

  always_comb begin
    xw_en   = 1'b0;
    xw_addr = 10'h0;
    xw_data = 32'h0;
    if (state_reg == ST_COPY && mode_reg == CP_GET) begin
      xw_en   = 1'b1;
      xw_addr = copy_w_reg;
      xw_data = store_mem[copy_w_reg];
    end else if (acc && !set_reg && sel == `SEL_HMB) begin
      xw_en   = 1'b1;
      xw_data = hmb_reg;
    end else if (hid_get) begin
      xw_en   = 1'b1;
      xw_data = hostid_reg[31:0];
    end else if (wr_en && paddr_i[`XFER_BIT]) begin
      xw_en   = 1'b1;
      xw_addr = paddr_i[11:2];
      xw_data = pwdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (xw_en) begin
      xfer_mem[xw_addr] <= xw_data;
      if (xw_addr[3:2] == 2'b01 && !xw_addr[1]) begin
        range_start_sh[xw_addr[9:4]][xw_addr[0]*32 +: 32] <= xw_data;
      end
      if (xw_addr[3:2] == 2'b01 && xw_addr[1]) begin
        range_count_sh[xw_addr[9:4]][xw_addr[0]*32 +: 32] <= xw_data;
      end
    end
    if (hid_get) begin
      xfer_mem[1] <= hostid_reg[63:32];
    end
  end

  always_ff @(posedge clk_i) begin
    if (state_reg == ST_COPY && mode_reg == CP_INIT) begin
      store_mem[copy_w_reg] <= dflt_word(copy_w_reg);
    end else if (state_reg == ST_COPY && mode_reg == CP_SET) begin
      store_mem[copy_w_reg] <= (copy_w_reg[9:4] <= num_reg) ?
                               xfer_mem[copy_w_reg] : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, no wait states
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_err;
  logic        busy;

  assign busy = start_reg || state_reg != ST_IDLE;

  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (paddr_i[`XFER_BIT]) begin
      rd_data = xfer_mem[paddr_i[11:2]];
      rd_err  = busy;
    end else begin
      unique case (paddr_i)
        `ARG10_OFF:  rd_data = arg10_reg;
        `ARG11_OFF:  rd_data = arg11_reg;
        `CTRL_OFF:   rd_data = {30'h0, set_reg, 1'b0};
        `RESULT_OFF: rd_data = result_reg;
        `STATUS_OFF: rd_data = {16'h0, status_reg, 6'h0, done_reg, busy};
        `CAPS_OFF:   rd_data = caps_reg;
        default:     rd_err  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= psel_i && !penable_i && !pready_reg;
      pslverr_reg <= psel_i && !penable_i && rd_err;
      prdata_reg  <= (psel_i && !penable_i && !pwrite_i) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arg10_reg <= 32'h0;
      arg11_reg <= 32'h0;
      set_reg   <= 1'b0;
      start_reg <= 1'b0;
      crst_reg  <= 1'b0;
      caps_reg  <= 32'h0;
    end else begin
      if (go) begin
        start_reg <= 1'b0;
      end
      crst_reg <= 1'b0;
      if (wr_en && !busy) begin
        unique case (paddr_i)
          `ARG10_OFF: arg10_reg <= pwdata_i;
          `ARG11_OFF: arg11_reg <= pwdata_i;
          `CAPS_OFF:  caps_reg  <= pwdata_i;
          `CTRL_OFF: begin
            set_reg   <= pwdata_i[`CTRL_SET_BIT];
            start_reg <= pwdata_i[`CTRL_START_BIT];
            crst_reg  <= pwdata_i[`CTRL_RST_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  assign prdata_o           = prdata_reg;
  assign pready_o           = pready_reg;
  assign pslverr_o          = pslverr_reg;
  assign arb_o              = arb_reg;
  assign pwr_o              = pwr_reg;
  assign power_state_load_o = load_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_arb_get;
    @(posedge clk_i) disable iff (!rst_n_i)
    (go && !set_reg && sel == `SEL_ARB) |=>
      result_reg == {arb_reg[26:3], 5'h0, arb_reg[2:0]};
  endproperty
  a_arb_get: assert property (p_arb_get) else $error("arb get wrong");

  property p_arb_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (acc && set_reg && sel == `SEL_ARB) |=>
      arb_o.high_class_weight == $past(arg11_reg[31:24]) &&
      arb_o.low_class_weight == $past(arg11_reg[15:8]) &&
      arb_o.queue_burst_limit == $past(arg11_reg[2:0]);
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("arb set lost");

  property p_pwr_abort;
    @(posedge clk_i) disable iff (!rst_n_i)
    (go && set_reg && sel == `SEL_PWR && arg11_reg[4:0] > psc &&
     feat_ok && !arg10_reg[`SAVE_BIT]) |=>
      status_reg == `SC_INVALID && $stable(pwr_o) && !power_state_load_o;
  endproperty
  a_pwr_abort: assert property (p_pwr_abort) else $error("bad state");

  property p_pwr_apply;
    @(posedge clk_i) disable iff (!rst_n_i)
    (acc && set_reg && sel == `SEL_PWR) |=>
      power_state_load_o && pwr_o == $past(arg11_reg[7:0]) && hmb_reg == 0;
  endproperty
  a_pwr_apply: assert property (p_pwr_apply) else $error("pwr lost");

  property p_nosave;
    @(posedge clk_i) disable iff (!rst_n_i)
    (go && set_reg && sel == `SEL_HMB && arg10_reg[`SAVE_BIT]) |=>
      status_reg == `SC_NOSAVE;
  endproperty
  a_nosave: assert property (p_nosave) else $error("save not refused");

  property p_reserved_sel;
    @(posedge clk_i) disable iff (!rst_n_i)
    (go && sel >= 8'h84 && sel <= 8'hbf) |=> status_reg == `SC_INVALID;
  endproperty
  a_reserved_sel: assert property (p_reserved_sel) else $error("rsvd");

  property p_unused_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == ST_COPY && mode_reg == CP_SET &&
     copy_w_reg[9:4] > num_reg) |=> store_mem[$past(copy_w_reg)] == 0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("dirty");

  property p_overlap;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == ST_CHECK && overlap) |=>
      status_reg == `SC_OVERLAP && state_reg == ST_IDLE && done_reg;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap missed");

  property p_crst;
    @(posedge clk_i) disable iff (!rst_n_i)
    (crst_reg && state_reg == ST_IDLE && !start_reg && !persist[0]) |=>
      arb_reg == `ARB_RST ##1 arb_reg == `ARB_RST;
  endproperty
  a_crst: assert property (p_crst) else $error("arb not restored");

  property p_lba_get;
    @(posedge clk_i) disable iff (!rst_n_i)
    (acc && !set_reg && sel == `SEL_LBA) |=>
      result_reg == {26'h0, lba_num_reg} && state_reg == ST_COPY;
  endproperty
  a_lba_get: assert property (p_lba_get) else $error("lba get");

  c_arb_set: cover property (@(posedge clk_i) acc && set_reg &&
                             sel == `SEL_ARB);
  c_lba_done: cover property (@(posedge clk_i) state_reg == ST_COPY &&
                              mode_reg == CP_SET &&
                              copy_w_reg == 10'(WORDS - 1) ##1 done_reg);
  c_overlap: cover property (@(posedge clk_i) state_reg == ST_CHECK &&
                             overlap);
  c_pwr_bad: cover property (@(posedge clk_i) go && set_reg &&
                             sel == `SEL_PWR && sc_next == `SC_INVALID);

endmodule : feature_config_decoder
`default_nettype wire

// file: rtl/feature_config_map.svh
`ifndef FEATURE_CONFIG_MAP_SVH
`define FEATURE_CONFIG_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARG10_OFF      13'h0000
`define ARG11_OFF      13'h0004
`define CTRL_OFF       13'h0008
`define RESULT_OFF     13'h000c
`define STATUS_OFF     13'h0010
`define CAPS_OFF       13'h0014
`define XFER_BIT       12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_START_BIT 0
`define CTRL_SET_BIT   1
`define CTRL_RST_BIT   2
`define CAPS_SAVE_BIT  4
`define CAPS_PSC_LSB   8
`define CAPS_RESV_BIT  16
`define CAPS_RCAP_BIT  17
`define SAVE_BIT       31

// ----------------------------------------------------------------
// Feature selectors and completion status codes
// ----------------------------------------------------------------
`define SEL_ARB        8'h01
`define SEL_PWR        8'h02
`define SEL_LBA        8'h03
`define SEL_HMB        8'h0d
`define SEL_MARK       8'h80
`define SEL_HOSTID     8'h81
`define SEL_RMASK      8'h82
`define SEL_RPERS      8'h83
`define SC_OK          8'h00
`define SC_INVALID     8'h02
`define SC_NOSAVE      8'h0d
`define SC_OVERLAP     8'h80

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ARB_RST        27'h0000000
`define PWR_RST        8'h00
`define LBA_ATTR_RST   8'h01
`define LBA_TYPE_RST   8'h00
`define PERSIST_COLS   8'h4c

`endif

// file: rtl/feature_config_pkg.sv
package feature_config_pkg;

  typedef struct packed {
    logic [7:0] high_class_weight;
    logic [7:0] medium_class_weight;
    logic [7:0] low_class_weight;
    logic [2:0] queue_burst_limit;
  } arb_s;

  typedef struct packed {
    logic [2:0] workload_hint;
    logic [4:0] power_state_select;
  } pwr_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_COPY  = 2'b11
  } state_e;

  typedef enum logic [1:0] {
    CP_INIT = 2'b00,
    CP_SET  = 2'b01,
    CP_GET  = 2'b10
  } copy_mode_e;

endpackage : feature_config_pkg

// file: tb/feature_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module feature_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output var  logic        psel_o,
  output var  logic        penable_o,
  output var  logic        pwrite_o,
  output var  logic [12:0] paddr_o,
  output var  logic [31:0] pwdata_o
);
  // ----
  // APB master
  // ----
  logic last_err;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 13'h0000;
    pwdata_o  = 32'h0000_0000;
    last_err  = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [12:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q        = prdata_i;
    last_err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // Released data must not keep showing the old word
    pwdata_o  <= ~d;
    @(posedge clk_i);
  endtask : xfer

  // ----
  // Range table in one contiguous block, unused words zero
  // ----
  task automatic put_range(input int idx, input logic [31:0] first_blk,
                           input logic [31:0] blk_cnt);
    logic [31:0] q;
    for (int w = 0; w < 16; w++) begin
      xfer(1'b1, 13'(32'h1000 + idx * 64 + w * 4),
           (w == 4) ? first_blk : (w == 6) ? blk_cnt : 32'h0, q);
    end
  endtask : put_range
endmodule : feature_host_model

`default_nettype wire

// file: tb/feature_config_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "feature_config_map.svh"

module feature_config_decoder_tb_top;
  import feature_config_pkg::*;
  // ----
  // Harness
  // ----
  logic        clk_i;
  logic        rst_n_i;
  logic        psel, penable, pwrite, pready, pslverr, power_state_load_o;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, q, st, res;
  arb_s        arb_o;
  pwr_s        pwr_o;
  int          error_cnt, check_count, load_cnt, n;
  logic [7:0]  bad [5] = '{8'h00, 8'h84, 8'hbf, 8'h81, 8'h0e};
  logic [12:0] ba [5] = '{13'h1000, 13'h1010, 13'h1018, 13'h101c, 13'h1040};
  logic [31:0] bv [5] = '{32'h100, 32'h0, 32'h000f_ffff, 32'h0, 32'h0};
  localparam logic [26:0] ARB_EXP = {8'hff, 8'hee, 8'hdd, 3'h7};

  feature_config_decoder i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .arb_o(arb_o), .pwr_o(pwr_o), .power_state_load_o(power_state_load_o));

  feature_host_model i_host (
    .clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (power_state_load_o === 1'b1) load_cnt++;

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [12:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic poll(input logic need_done);
    for (int i = 0; i < 3000; i++) begin
      rd(`STATUS_OFF);
      if (q[0] === 1'b0 && (q[1] === 1'b1 || !need_done)) break;
    end
  endtask : poll

  task automatic cmd(input logic set, input logic [31:0] a10, a11);
    wr(`ARG10_OFF, a10);
    wr(`ARG11_OFF, a11);
    wr(`CTRL_OFF, {30'h0, set, 1'b1});
    poll(1'b1);
    st = q;
    rd(`RESULT_OFF);
    res = q;
  endtask : cmd

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end

  // ----
  // Tests
  // ----
  initial begin
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    poll(1'b0);
    rd(13'h0100);
    chk(32'(i_host.last_err), 32'h1);
    wr(`CAPS_OFF, 32'h0000_0300);
    cmd(1'b1, 32'h01, 32'hffee_ddff);
    chk(32'(arb_o), 32'(ARB_EXP));
    cmd(1'b0, 32'h01, 32'h0);
    chk(res, 32'hffee_dd07);
    cmd(1'b1, 32'h8000_0001, 32'h0);
    chk(32'(st[15:8]), 32'(`SC_NOSAVE));
    n = load_cnt;
    cmd(1'b1, 32'h02, 32'hffff_ff63);
    chk(32'(pwr_o), 32'h63);
    chk(load_cnt, n + 1);
    cmd(1'b0, 32'h02, 32'h0);
    chk(res, 32'h63);
    cmd(1'b1, 32'h02, 32'h04);
    chk(32'(st[15:8]), 32'(`SC_INVALID));
    chk(32'(pwr_o), 32'h63);
    foreach (bad[i]) begin
      cmd(1'b0, 32'(bad[i]), 32'h0);
      chk(32'(st[15:8]), 32'(`SC_INVALID));
    end
    cmd(1'b1, 32'h0d, 32'h0000_abcd);
    cmd(1'b0, 32'h0d, 32'h0);
    chk(res, 32'h0000_abcd);
    rd(13'h1000);
    chk(q, 32'h0000_abcd);
    cmd(1'b1, 32'h80, 32'h1234_5678);
    wr(`CTRL_OFF, 32'h4);
    poll(1'b0);
    chk(32'(arb_o), 32'h0);
    chk(32'(pwr_o), 32'h0);
    cmd(1'b0, 32'h80, 32'h0);
    chk(res, 32'h1234_5678);
    cmd(1'b0, 32'h0d, 32'h0);
    chk(res, 32'h0);
    wr(`CAPS_OFF, 32'h0001_0300);
    wr(13'h1000, 32'h0000_cafe);
    wr(13'h1004, 32'h0000_beef);
    cmd(1'b1, 32'h81, 32'h0);
    chk(32'(st[15:8]), 32'(`SC_OK));
    wr(13'h1000, 32'h0);
    wr(13'h1004, 32'h0);
    cmd(1'b0, 32'h81, 32'h0);
    rd(13'h1000);
    chk(q, 32'h0000_cafe);
    rd(13'h1004);
    chk(q, 32'h0000_beef);
    cmd(1'b0, 32'h03, 32'h3f);
    chk(32'(st[15:8]), 32'(`SC_OK));
    chk(res, 32'h0);
    foreach (ba[i]) begin
      rd(ba[i]);
      chk(q, bv[i]);
    end
    i_host.put_range(0, 32'h0, 32'h9);
    // Second range starts inside the first on purpose
    i_host.put_range(1, 32'h5, 32'h0);
    cmd(1'b1, 32'h03, 32'h1);
    chk(32'(st[15:8]), 32'(`SC_OVERLAP));
    i_host.put_range(1, 32'h20, 32'h3);
    cmd(1'b1, 32'h03, 32'h1);
    chk(32'(st[15:8]), 32'(`SC_OK));
    cmd(1'b0, 32'h03, 32'h0);
    chk(res, 32'h1);
    rd(13'h1050);
    chk(q, 32'h20);
    rd(13'h1080);
    chk(q, 32'h0);
    // Save support on: only features once saved survive a controller reset
    wr(`CAPS_OFF, 32'h0001_0310);
    cmd(1'b1, 32'h8000_0001, 32'h0102_0304);
    chk(32'(st[15:8]), 32'(`SC_OK));
    wr(`CTRL_OFF, 32'h4);
    poll(1'b0);
    chk(32'(arb_o), 32'({8'h01, 8'h02, 8'h03, 3'h4}));
    cmd(1'b0, 32'h80, 32'h0);
    chk(res, 32'h0);
    cmd(1'b0, 32'h03, 32'h0);
    chk(res, 32'h0);
    end_sim();
  end
endmodule : feature_config_decoder_tb_top

`default_nettype wire
